// [core/ipc_arbiter.sv]
// Combinational three-level arbiter with fixed natural order inside each level.
// Assumes source 0 is power-fail and its request is already gated by its enable.
`timescale 1ns/10ps
module ipc_arbiter (
	ipc_req_if.arb rq
);

	// Lowest set index wins; index order equals natural rank order.
	function automatic logic [4:0] ipc_first(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = ipc_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	wire [15:0] hiReq = rq.pending & rq.highSel;
	wire [15:0] loReq = rq.pending & ~rq.highSel;
	wire [4:0]  hiPick = ipc_first(hiReq);
	wire [4:0]  loPick = ipc_first(loReq);
	wire        pfReq  = rq.pending[ipc_pkg::SRC_PFAIL];

	assign rq.winValid = pfReq | hiPick[4] | loPick[4];
	assign rq.winIdx   = pfReq ? 4'(ipc_pkg::SRC_PFAIL) : (hiPick[4] ? hiPick[3:0] : loPick[3:0]);
	assign rq.winLevel = pfReq ? ipc_pkg::IPC_LVL_PFAIL :
	                     hiPick[4] ? ipc_pkg::IPC_LVL_HIGH :
	                     loPick[4] ? ipc_pkg::IPC_LVL_LOW : ipc_pkg::IPC_LVL_NONE;

endmodule

// [core/ipc_controller.sv]
// Interrupt priority controller: qualifies fourteen sources in sixteen rank slots (ranks 2 and 3 tied off), arbitrates, tracks in-service level.
// Assumes register images and flags are synchronous inputs; core pulses ack and return.
//
// Notes on behaviour
// - Fourteen sources are accepted (ranks 2 and 3 are tied to zero) and arbitrated over three levels.
// - Enabled power-fail always wins and vectors to 33h; enable bit 5, flag bit 4.
// - Every other source picks high or low level by its own priority bit.
// - Among equal-level pending requests, the smallest natural rank wins.
// - Added sources rank below the classic seven, power-fail excepted.
// - Serial port 0 request is transmit OR receive; 23h, rank 6, enable/priority bit 4.
// - Converter end-of-conversion: 4Bh, rank 10, flag bit 6, extended bit 1.
// - Two-wire port one: 43h, rank 9, control flag bit 4, extended bit 0.
// - Two-wire port two: 53h, rank 11, control flag bit 4, extended bit 2.
// - Buffer one input-full: 63h, rank 13, status bit 1, extended bit 4.
// - Buffer two input-full: 7Bh, rank 16, status bit 1, extended bit 7.
`timescale 1ns/10ps
module ipc_controller (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic [7:0]  watchdog_control_reg,
	input  wire logic [7:0]  main_irq_enable_reg,
	input  wire logic [7:0]  main_irq_priority_reg,
	input  wire logic [7:0]  extended_irq_enable_reg,
	input  wire logic [7:0]  extended_irq_priority_reg,
	input  wire logic        uart0_tx_done_flag,
	input  wire logic        uart0_rx_done_flag,
	input  wire logic [7:0]  converter_control_reg_one,
	input  wire logic [7:0]  twowire_one_control_reg,
	input  wire logic [7:0]  twowire_two_control_reg,
	input  wire logic [7:0]  pm_buffer_one_status_reg,
	input  wire logic [7:0]  pm_buffer_two_status_reg,
	input  wire logic [5:0]  otherFlags,
	input  wire logic        irqAck,
	input  wire logic        irqReturn,
	output logic             irqRequest,
	output logic [7:0]       irqVector,
	output logic [1:0]       activeLevel
);

	////////////////////////////////////////////////////////////////////////////
	// Source qualification.

	ipc_req_if rq ();

	logic [15:0] flags;
	logic [15:0] enables;
	wire         globalEn = main_irq_enable_reg[7];
	wire         pfEn     = watchdog_control_reg[ipc_pkg::WD_PFAIL_EN_BIT];

	wire uart0Flag = uart0_tx_done_flag | uart0_rx_done_flag;

	// sixteen flags, added sources after rank 8; otherFlags feed sources without own ports.
	// converter flag. two-wire one. two-wire two. buffer one. buffer two.
	assign flags = {
		pm_buffer_two_status_reg[ipc_pkg::PMBUF_FULL_BIT],
		watchdog_control_reg[ipc_pkg::WD_WDT_FLAG_BIT],
		otherFlags[5],
		pm_buffer_one_status_reg[ipc_pkg::PMBUF_FULL_BIT],
		otherFlags[4],
		twowire_two_control_reg[ipc_pkg::TWOWIRE_FLAG_BIT],
		converter_control_reg_one[ipc_pkg::CONV_EOC_BIT],
		twowire_one_control_reg[ipc_pkg::TWOWIRE_FLAG_BIT],
		otherFlags[3],
		otherFlags[2],
		uart0Flag,
		otherFlags[1:0],
		2'b00,
		watchdog_control_reg[ipc_pkg::WD_PFAIL_FLAG_BIT]
	};

	// enable gating; power-fail bypasses the global enable so it always wins.
	// Ranks 2 to 8 take main enable bits 0 to 6, ranks 9 to 16 the extended enable byte.
	assign enables = {extended_irq_enable_reg & {8{globalEn}}, main_irq_enable_reg[6:0] & {7{globalEn}}, pfEn};

	assign rq.highSel = {extended_irq_priority_reg, main_irq_priority_reg[6:0], 1'b1};
	assign rq.pending = flags & enables;

	ipc_arbiter uArb (
		.rq (rq.arb)
	);

	////////////////////////////////////////////////////////////////////////////
	// In-service tracking, one bit per level: bit 0 low, bit 1 high, bit 2 power-fail.
	// A mask replaces a short stack: after low, high and power-fail nest, the low handler is still known.

	logic [2:0]          inSvc_r;
	logic [2:0]          inSvc_nxt;
	ipc_pkg::ipc_level_t curLvl;

	// Highest level whose handler is still in service.
	function automatic ipc_pkg::ipc_level_t ipc_top(input logic [2:0] m);
		ipc_pkg::ipc_level_t l;
		l = ipc_pkg::IPC_LVL_NONE;
		if (m[0]) begin
			l = ipc_pkg::IPC_LVL_LOW;
		end
		if (m[1]) begin
			l = ipc_pkg::IPC_LVL_HIGH;
		end
		if (m[2]) begin
			l = ipc_pkg::IPC_LVL_PFAIL;
		end
		return l;
	endfunction

	// In-service bit of one level; the idle level owns none.
	function automatic logic [2:0] ipc_lvl_bit(input ipc_pkg::ipc_level_t l);
		logic [2:0] b;
		unique case (l)
			ipc_pkg::IPC_LVL_NONE:  b = 3'h0;
			ipc_pkg::IPC_LVL_LOW:   b = 3'h1;
			ipc_pkg::IPC_LVL_HIGH:  b = 3'h2;
			ipc_pkg::IPC_LVL_PFAIL: b = 3'h4;
		endcase
		return b;
	endfunction

	// Level now in service, the reference for any preemption.
	assign curLvl = ipc_top(inSvc_r);

	// preempt only above level in service.
	wire canPreempt = rq.winValid && (rq.winLevel > curLvl);
	wire takeAck    = irqAck && irqRequest;

	// push and pop. An ack wins over a return in the same cycle; a return clears only the top level.
	always_comb begin
		inSvc_nxt = inSvc_r;
		if (takeAck) begin
			inSvc_nxt = inSvc_r | ipc_lvl_bit(ipc_pkg::ipc_level_t'(activeLevel));
		end else if (irqReturn) begin
			inSvc_nxt = inSvc_r & ~ipc_lvl_bit(curLvl);
		end
	end

	// Level of the pending winner is latched with the vector so the ack uses a stable pair.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			inSvc_r     <= 3'h0;
			irqRequest  <= 1'b0;
			irqVector   <= ipc_pkg::VEC_IDLE;
			activeLevel <= 2'b00;
		end else begin
			inSvc_r     <= inSvc_nxt;
			irqRequest  <= canPreempt && !takeAck;
			irqVector   <= canPreempt ? ipc_pkg::VEC_TABLE[rq.winIdx] : ipc_pkg::VEC_IDLE;
			activeLevel <= takeAck ? 2'(ipc_top(inSvc_nxt)) : 2'(rq.winLevel);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks. Vectors and bit places are written out as literals, so a slip in the tables is caught here.

	a_pfail_vector: assert property (@(posedge clock) disable iff (!arst_n)
		(rq.pending[ipc_pkg::SRC_PFAIL] && curLvl != ipc_pkg::IPC_LVL_PFAIL && !irqAck)
		|=> irqRequest && irqVector == 8'h33)
		else $error("Power-fail did not vector to 33h.");

	a_pfail_level: assert property (@(posedge clock) disable iff (!arst_n)
		(rq.pending[ipc_pkg::SRC_PFAIL] && !irqAck) |=> activeLevel == 2'h3)
		else $error("Power-fail not shown at the top level.");

	a_pfail_gate: assert property (@(posedge clock) disable iff (!arst_n)
		rq.pending[0] == (watchdog_control_reg[5] && watchdog_control_reg[4]))
		else $error("Power-fail request does not follow its flag and enable.");

	a_high_level: assert property (@(posedge clock) disable iff (!arst_n)
		(!irqAck && !rq.pending[0] && (rq.pending[15:1] & rq.highSel[15:1]) != 15'h0000)
		|=> activeLevel == 2'h2)
		else $error("High-level request not shown at the high level.");

	a_rank_order: assert property (@(posedge clock) disable iff (!arst_n)
		(rq.winValid && rq.winLevel == ipc_pkg::IPC_LVL_LOW)
		|-> rq.pending[rq.winIdx] &&
		((rq.pending & ~rq.highSel & ((16'h0001 << rq.winIdx) - 16'h0001)) == 16'h0000))
		else $error("Low-level winner is not the smallest pending rank.");

	a_added_rank: assert property (@(posedge clock) disable iff (!arst_n)
		(rq.winValid && rq.winLevel == ipc_pkg::IPC_LVL_LOW &&
		(rq.pending[7:1] & ~rq.highSel[7:1]) != 7'h00) |-> rq.winIdx < 4'h8)
		else $error("Added source beat a classic source.");

	a_serial_or: assert property (@(posedge clock) disable iff (!arst_n)
		rq.pending[5] == ((uart0_tx_done_flag || uart0_rx_done_flag) &&
		main_irq_enable_reg[7] && main_irq_enable_reg[4]))
		else $error("Serial request is not transmit or receive.");

	a_uart_vector: assert property (@(posedge clock) disable iff (!arst_n)
		(rq.winValid && rq.winIdx == 4'(ipc_pkg::SRC_UART0) && canPreempt)
		|=> irqVector == 8'h23)
		else $error("Serial vector wrong.");

	a_conv_vector: assert property (@(posedge clock) disable iff (!arst_n)
		(canPreempt && rq.winIdx == 4'(ipc_pkg::SRC_CONV)) |=> irqVector == 8'h4b)
		else $error("Converter vector wrong.");

	a_twi_one: assert property (@(posedge clock) disable iff (!arst_n)
		(canPreempt && rq.winIdx == 4'(ipc_pkg::SRC_TWI1)) |=> irqVector == 8'h43)
		else $error("Two-wire one vector wrong.");

	a_twi_two: assert property (@(posedge clock) disable iff (!arst_n)
		(canPreempt && rq.winIdx == 4'(ipc_pkg::SRC_TWI2)) |=> irqVector == 8'h53)
		else $error("Two-wire two vector wrong.");

	a_pmbuf_one: assert property (@(posedge clock) disable iff (!arst_n)
		(canPreempt && rq.winIdx == 4'(ipc_pkg::SRC_PMBUF1)) |=> irqVector == 8'h63)
		else $error("Buffer one vector wrong.");

	a_pmbuf_two: assert property (@(posedge clock) disable iff (!arst_n)
		(canPreempt && rq.winIdx == 4'(ipc_pkg::SRC_PMBUF2)) |=> irqVector == 8'h7b)
		else $error("Buffer two vector wrong.");

	a_no_same_level: assert property (@(posedge clock) disable iff (!arst_n)
		(rq.winLevel <= curLvl) |=> !irqRequest)
		else $error("Same-level preemption.");

	a_gate_enable: assert property (@(posedge clock) disable iff (!arst_n)
		(rq.pending == 16'h0000) |=> !irqRequest)
		else $error("Request without enabled flag.");

	a_global_gate: assert property (@(posedge clock) disable iff (!arst_n)
		!main_irq_enable_reg[7] |-> rq.pending[15:1] == 15'h0000)
		else $error("Request passed a cleared global enable.");

	a_ack_drops: assert property (@(posedge clock) disable iff (!arst_n)
		takeAck |=> !irqRequest)
		else $error("Request still shown after its acknowledge.");

	a_low_kept: assert property (@(posedge clock) disable iff (!arst_n)
		(inSvc_r[0] && (inSvc_r[2:1] != 2'h0 || !irqReturn)) |=> inSvc_r[0])
		else $error("Low handler lost while still in service.");

	// Main scenarios: power-fail, nesting, nested return and high over an active low handler.
	c_pfail: cover property (@(posedge clock) disable iff (!arst_n) irqRequest && irqVector == 8'h33);
	c_nested: cover property (@(posedge clock) disable iff (!arst_n)
		curLvl == ipc_pkg::IPC_LVL_LOW ##1 takeAck);
	c_return: cover property (@(posedge clock) disable iff (!arst_n) irqReturn && inSvc_r[1] && inSvc_r[0]);
	c_high_over_low: cover property (@(posedge clock) disable iff (!arst_n)
		irqRequest && activeLevel == 2'h2 && inSvc_r[0]);

endmodule

// [include/ipc_pkg.sv]
// Constants, vector addresses and the arbitration level type of the interrupt priority controller.
// Assumes the core presents raw flags and register images synchronous to the one core clock.
package ipc_pkg;

	localparam int NUM_SRC = 16;
	localparam int LVL_W   = 2;

	// Arbitration levels, lowest first.
	typedef enum logic [1:0] {
		IPC_LVL_NONE,
		IPC_LVL_LOW,
		IPC_LVL_HIGH,
		IPC_LVL_PFAIL
	} ipc_level_t;

	// Register bit positions.
	localparam int WD_PFAIL_EN_BIT   = 5;
	localparam int WD_PFAIL_FLAG_BIT = 4;
	localparam int WD_WDT_FLAG_BIT   = 3;
	localparam int UART0_ENABLE_BIT  = 4;
	localparam int UART0_RX_BIT      = 0;
	localparam int UART0_TX_BIT      = 1;
	localparam int CONV_EOC_BIT      = 6;
	localparam int TWOWIRE_FLAG_BIT  = 4;
	localparam int PMBUF_FULL_BIT    = 1;
	localparam int EXT_TWOWIRE1_BIT  = 0;
	localparam int EXT_CONV_BIT      = 1;
	localparam int EXT_TWOWIRE2_BIT  = 2;
	localparam int EXT_PMBUF1_BIT    = 4;
	localparam int EXT_PMBUF2_BIT    = 7;

	// Source index = natural rank minus one.
	localparam int SRC_PFAIL  = 0;
	localparam int SRC_UART0  = 5;
	localparam int SRC_TWI1   = 8;
	localparam int SRC_CONV   = 9;
	localparam int SRC_TWI2   = 10;
	localparam int SRC_PMBUF1 = 12;
	localparam int SRC_PMBUF2 = 15;

	localparam logic [7:0] VEC_IDLE = 8'h00;
	localparam logic [7:0] VEC_TABLE [NUM_SRC] = '{
		8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h3b,
		8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63, 8'h6b, 8'h73, 8'h7b
	};

	localparam logic [3:0] RANK_NONE = 4'h0;

endpackage

// [include/ipc_req_if.sv]
// Carrier of the qualified request and priority vectors between the main block and its arbiter.
// Assumes both ends share the core clock.
`timescale 1ns/10ps
interface ipc_req_if;
	logic [15:0] pending;
	logic [15:0] highSel;
	logic        winValid;
	logic [3:0]  winIdx;
	ipc_pkg::ipc_level_t winLevel;

	modport ctrl (output pending, output highSel, input winValid, input winIdx, input winLevel);
	modport arb  (input pending, input highSel, output winValid, output winIdx, output winLevel);
endinterface

// [verif/interrupt_priority_controller_tb.sv]
// Self-checking bench: drives flags and enable images, a core model takes and returns vectors.
// Assumes registered outputs settle one cycle after inputs change at the falling edge.
`timescale 1ns/10ps
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin miscompares++; $display("FAIL %0t got %h exp %h", $time, got, exp); end end
module interrupt_priority_controller_tb;
	logic       clock = 1'b0, arst_n = 1'b0, irqAck, irqReturn, irqRequest, txF = 1'b0, rxF = 1'b0;
	logic       autoAck = 1'b0, retStrobe = 1'b0;
	logic [7:0] wdReg = 8'h20, ieReg = 8'hff, ipReg = 8'h00, eieReg = 8'hff, eipReg = 8'h00;
	logic [7:0] convReg = 8'h00, tw1Reg = 8'h00, tw2Reg = 8'h00, pm1Reg = 8'h00, pm2Reg = 8'h00;
	logic [7:0] irqVector, takenVector, ackCount;
	logic [5:0] otherF = 6'h00;
	logic [1:0] activeLevel;
	int         miscompares = 0, nChecks = 0;

	ipc_controller u_dut (.clock(clock), .arst_n(arst_n), .watchdog_control_reg(wdReg),
		.main_irq_enable_reg(ieReg), .main_irq_priority_reg(ipReg), .extended_irq_enable_reg(eieReg),
		.extended_irq_priority_reg(eipReg), .uart0_tx_done_flag(txF), .uart0_rx_done_flag(rxF),
		.converter_control_reg_one(convReg), .twowire_one_control_reg(tw1Reg),
		.twowire_two_control_reg(tw2Reg), .pm_buffer_one_status_reg(pm1Reg),
		.pm_buffer_two_status_reg(pm2Reg), .otherFlags(otherF), .irqAck(irqAck), .irqReturn(irqReturn),
		.irqRequest(irqRequest), .irqVector(irqVector), .activeLevel(activeLevel));
	ipc_core_model u_core (.clock(clock), .arst_n(arst_n), .irqRequest(irqRequest), .irqVector(irqVector),
		.autoAck(autoAck), .ackDelay(4'h2), .retStrobe(retStrobe), .irqAck(irqAck), .irqReturn(irqReturn),
		.takenVector(takenVector), .ackCount(ackCount));

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Clock at 40 MHz; every input change happens at the falling edge so no edge race exists.
	initial begin
		forever #12.5 clock = ~clock;
	end

	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic setFlag(input int i, input logic v);
		case (i)
			0: wdReg[4] = v;
			3, 4: otherF[i - 3] = v;
			5: txF = v;
			6, 7: otherF[i - 4] = v;
			8: tw1Reg[4] = v;
			9: convReg[6] = v;
			10: tw2Reg[4] = v;
			11: otherF[4] = v;
			12: pm1Reg[1] = v;
			13: otherF[5] = v;
			14: wdReg[3] = v;
			15: pm2Reg[1] = v;
			default: ;
		endcase
	endtask

	// Vectors are spaced by eight, with the power-fail slot at 33h left out of the sequence.
	function automatic logic [7:0] expVec(input int i);
		if (i == 0) return 8'h33;
		if (i <= 6) return 8'h03 + 8'(8 * (i - 1));
		return 8'h3b + 8'(8 * (i - 7));
	endfunction

	task automatic look(input logic req, input logic [7:0] vec, input logic [1:0] lvl);
		`CHK(irqRequest, req)
		`CHK(irqVector, vec)
		`CHK(activeLevel, lvl)
	endtask

	// One handler return, then time for the pop and the next request to register.
	task automatic retPulse();
		retStrobe = 1'b1;
		step(1);
		retStrobe = 1'b0;
		step(3);
	endtask

	task automatic complete_run();
		$display("Checks %0d, miscompares %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// A core that never acknowledges would hang the run, so the wait is bounded.
	task automatic waitAck(input logic [7:0] n);
		int k;
		k = 0;
		while (ackCount !== n && k < 40) begin
			step(1);
			k++;
		end
		if (ackCount !== n) begin
			miscompares++;
			$display("FAIL %0t acknowledge wait ran out", $time);
			complete_run();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Scenarios: rank walk, serial receive, level selection, preemption and nested return.
	initial begin
		step(3);
		arst_n = 1'b1;
		step(1);
		look(1'b0, 8'h00, 2'h0);
		for (int i = 0; i < 16; i++) setFlag(i, 1'b1);
		step(2);
		for (int i = 0; i < 16; i++) begin
			if (i != 1 && i != 2) look(1'b1, expVec(i), (i == 0) ? 2'h3 : 2'h1);
			setFlag(i, 1'b0);
			step(2);
		end
		look(1'b0, 8'h00, 2'h0);
		rxF = 1'b1;
		step(2);
		look(1'b1, 8'h23, 2'h1);
		rxF = 1'b0;
		setFlag(3, 1'b1);
		setFlag(15, 1'b1);
		eipReg[7] = 1'b1;
		step(2);
		look(1'b1, 8'h7b, 2'h2);
		setFlag(0, 1'b1);
		step(2);
		look(1'b1, 8'h33, 2'h3);
		ieReg[7] = 1'b0;
		step(2);
		look(1'b1, 8'h33, 2'h3);
		ieReg[7] = 1'b1;
		wdReg[5] = 1'b0;
		step(2);
		look(1'b1, 8'h7b, 2'h2);
		eieReg[7] = 1'b0;
		step(2);
		look(1'b1, 8'h13, 2'h1);
		eieReg = 8'hff;
		setFlag(15, 1'b0);
		autoAck = 1'b1;
		waitAck(8'h01);
		`CHK(takenVector, 8'h13)
		setFlag(4, 1'b1);
		step(3);
		`CHK(irqRequest, 1'b0)
		setFlag(15, 1'b1);
		waitAck(8'h02);
		`CHK(takenVector, 8'h7b)
		autoAck = 1'b0;
		setFlag(15, 1'b0);
		setFlag(3, 1'b0);
		retPulse();
		`CHK(irqRequest, 1'b0)
		retPulse();
		look(1'b1, 8'h1b, 2'h1);
		// Three-deep nesting: low, then high, then power-fail; two returns must leave low in service.
		autoAck = 1'b1;
		waitAck(8'h03);
		`CHK(takenVector, 8'h1b)
		setFlag(15, 1'b1);
		waitAck(8'h04);
		`CHK(takenVector, 8'h7b)
		wdReg[5] = 1'b1;
		waitAck(8'h05);
		`CHK(takenVector, 8'h33)
		autoAck = 1'b0;
		setFlag(0, 1'b0);
		setFlag(15, 1'b0);
		retPulse();
		retPulse();
		`CHK(irqRequest, 1'b0)
		retPulse();
		look(1'b1, 8'h1b, 2'h1);
		complete_run();
	end
endmodule

// [verif/ipc_core_model.sv]
// Behavioural core sequencer that takes presented vectors and signals handler return.
// Assumes the controller's outputs are registered on the rising edge of the core clock.
`timescale 1ns/10ps
module ipc_core_model (
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       irqRequest,
	input  wire logic [7:0] irqVector,
	input  wire logic       autoAck,
	input  wire logic [3:0] ackDelay,
	input  wire logic       retStrobe,
	output logic            irqAck,
	output logic            irqReturn,
	output logic [7:0]      takenVector,
	output logic [7:0]      ackCount
);
	logic [3:0] waitCnt;

	// Ack is held until it is sampled with a request, or until the request drops; a slow core first waits ackDelay cycles.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irqAck      <= 1'b0;
			irqReturn   <= 1'b0;
			waitCnt     <= 4'h0;
			takenVector <= 8'h00;
			ackCount    <= 8'h00;
		end else begin
			irqReturn <= retStrobe;
			if (irqAck && irqRequest) begin
				irqAck      <= 1'b0;
				waitCnt     <= 4'h0;
				takenVector <= irqVector;
				ackCount    <= ackCount + 8'h01;
			end else if (irqRequest && autoAck && waitCnt >= ackDelay) begin
				irqAck <= 1'b1;
			end else if (irqRequest && autoAck) begin
				waitCnt <= waitCnt + 4'h1;
			end else begin
				irqAck  <= 1'b0;
				waitCnt <= 4'h0;
			end
		end
	end
endmodule
